// ===== hdl/brc_ctrl.sv
// Purpose: read, retry and timer control fields of the bridge
// Assumes: APB slave, zero wait states, inputs other than RESETN synchronous
// Notes:   per-transaction settings are caught at TX_START
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE_01 - sdr clear: changed command repeat is retried
// RULE_02 - sdr set: memory read command swap accepted
// RULE_03 - bit 11 enables malformed check, resets off
// RULE_04 - bits 14:12 max read count, reset 000
// RULE_05 - byte count decode table for the field
// RULE_06 - bit 15 picks update per one/two credits
// RULE_07 - bit 16 sticky retry expiry, write one clears
// RULE_08 - bits 18:17 retry limit none/256/64K/2G
// RULE_09 - bit 19 disables the discard timer
// RULE_10 - bit 20 makes discard timer 64 clocks
// RULE_11 - config retry timer 25us or 0.5ms
// RULE_12 - config retry 5ms or 25ms, reset 01
// RULE_13 - full prefetch is mode code 10; read line and read multiple take any nonzero code
// RULE_14 - retry counter clears, expiry abandons transaction
// RULE_15 - zero write keeps sticky, settings per transaction
module brc_ctrl #(
   parameter int CRT1_N  = brc_pkg::CRT1_CLKS, // 0.5 ms in cycles
   parameter int CRT2_N  = brc_pkg::CRT2_CLKS, // 5 ms in cycles
   parameter int CRT3_N  = brc_pkg::CRT3_CLKS, // 25 ms in cycles
   parameter int DTL_N   = brc_pkg::DT_LONG,   // long discard count
   parameter int RC_MID  = brc_pkg::RC_LIM2,   // 64K retries
   parameter int RC_MAX  = brc_pkg::RC_LIM3    // 2G retries
) (
   input  wire logic        CLK,
   input  wire logic        RESETN,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic [31:0]      PRDATA,
   // transaction from the pci side
   input  wire logic        TX_START,
   input  wire logic [3:0]  TX_CMD,
   input  wire logic        TX_DONE,
   input  wire logic        RETRY_ISSUED,
   input  wire logic        RPT_VALID,
   input  wire logic [3:0]  RPT_CMD,
   input  wire logic        RPT_MATCH,
   output logic             RPT_RETRY,
   output logic             RPT_ACCEPT,
   output logic             TX_ABANDON,
   output logic             FULL_PF,
   output logic [12:0]      MAX_RD_BYTES,
   // pcie side
   output logic             MALF_CHECK_EN,
   input  wire logic        CREDIT_FREED,
   output logic             FC_UPDATE,
   // timers
   input  wire logic        DT_SEL,
   input  wire logic        DT_START,
   input  wire logic        DT_STOP,
   output logic             DT_EXPIRE,
   input  wire logic        CRS_START,
   input  wire logic        CRS_STOP,
   output logic             CRS_EXPIRE,
   // interrupt
   output logic             IRQ
);
   localparam int TW = brc_pkg::TMR_W;

   // software fields
   logic       sdr_reg;   // special delayed read
   logic       malf_reg;  // malformed check enable
   logic [2:0] mrbc_reg;  // max read byte count code
   logic       fcu_reg;   // update per single credit
   logic       rcst_reg;  // retry expiry sticky
   logic [1:0] rcl_reg;   // retry limit code
   logic       dtdis_reg; // discard timer disable
   logic       dtsh_reg;  // discard short duration
   logic [1:0] crt_reg;   // config retry timer code
   logic [1:0] pfrd_reg;  // read prefetch mode
   logic [1:0] pfln_reg;  // read line prefetch mode
   logic [1:0] pfmu_reg;  // read multiple prefetch mode
   logic [brc_pkg::IS_W-1:0] ist_reg;  // interrupt status
   logic [brc_pkg::IS_W-1:0] imsk_reg; // interrupt mask

   // per-transaction copies
   logic        sdr_tx_reg;  // sdr seen at start
   logic [3:0]  pcmd_reg;    // pending command code
   logic [1:0]  rcl_tx_reg;  // limit seen at start

   // bus decode
   logic        setup;     // setup phase of a transfer
   logic        wr_acc;    // write taking effect
   logic        hit_c0;    // address decode hits
   logic        hit_pf;
   logic        hit_is;
   logic        hit_im;
   logic        mapped;
   logic [31:0] rd_next;   // read mux

   // events
   logic        rc_expire; // retry counter limit reached
   logic        dt_exp;    // discard timer expiry pulse
   logic        crs_exp;   // config retry expiry pulse
   logic        rpt_same;  // repeat kept its command
   logic        rpt_swap;  // allowed memory read swap
   logic        rpt_ok;
   logic        fc_half_reg; // one credit held back
   logic [31:0] rc_limit;
   logic [TW-1:0] dt_len;
   logic [TW-1:0] crs_len;
   logic [brc_pkg::IS_W-1:0] ev;

   // true for the three memory read commands
   function automatic logic is_mrd(input logic [3:0] c);
      is_mrd = (c == brc_pkg::CMD_MR) || (c == brc_pkg::CMD_MRL) ||
               (c == brc_pkg::CMD_MRM);
   endfunction

   // byte count for a max read code
   function automatic logic [12:0] mrbc_bytes(input logic [2:0] c);
      case (c)
         3'h1:    mrbc_bytes = 13'h0080; // RULE_05
         3'h2:    mrbc_bytes = 13'h0100;
         3'h4:    mrbc_bytes = 13'h0400;
         3'h5:    mrbc_bytes = 13'h0800;
         3'h6:    mrbc_bytes = 13'h1000;
         default: mrbc_bytes = 13'h0200; // 000, 011, 111
      endcase
   endfunction

   // retry count for a limit code, zero means unlimited
   function automatic logic [31:0] rc_lim(input logic [1:0] c);
      case (c)
         2'h1:    rc_lim = 32'(brc_pkg::RC_LIM1); // RULE_08
         2'h2:    rc_lim = 32'(RC_MID);
         2'h3:    rc_lim = 32'(RC_MAX);
         default: rc_lim = 32'h0000_0000;
      endcase
   endfunction

   // ---------------- apb slave ----------------
   assign setup  = PSEL && !PENABLE;
   assign wr_acc = PSEL && PENABLE && PWRITE;
   // zero wait states: the answer is ready in the access phase
   assign PREADY = 1'b1;

   // address decode
   always_comb begin
      hit_c0 = 1'b0;
      hit_pf = 1'b0;
      hit_is = 1'b0;
      hit_im = 1'b0;
      if (PADDR == brc_pkg::OFF_CTRL0) begin
         hit_c0 = 1'b1;
      end else if (PADDR == brc_pkg::OFF_PFCTL) begin
         hit_pf = 1'b1;
      end else if (PADDR == brc_pkg::OFF_ISTAT) begin
         hit_is = 1'b1;
      end else if (PADDR == brc_pkg::OFF_IMASK) begin
         hit_im = 1'b1;
      end
   end
   assign mapped  = hit_c0 || hit_pf || hit_is || hit_im;
   // unmapped access is refused in the access phase only
   assign PSLVERR = PSEL && PENABLE && !mapped;

   // read data assembly, unused bits read zero
   always_comb begin
      rd_next = 32'h0000_0000;
      if (hit_c0) begin
         rd_next[brc_pkg::B_SDR]       = sdr_reg;
         rd_next[brc_pkg::B_MALF]      = malf_reg;
         rd_next[brc_pkg::F_MRBC +: 3] = mrbc_reg;
         rd_next[brc_pkg::B_FCU]       = fcu_reg;
         rd_next[brc_pkg::B_RCST]      = rcst_reg;
         rd_next[brc_pkg::F_RCL +: 2]  = rcl_reg;
         rd_next[brc_pkg::B_DTDIS]     = dtdis_reg;
         rd_next[brc_pkg::B_DTSHORT]   = dtsh_reg;
         rd_next[brc_pkg::F_CRT +: 2]  = crt_reg;
      end else if (hit_pf) begin
         rd_next[brc_pkg::F_PF_RD +: 2] = pfrd_reg;
         rd_next[brc_pkg::F_PF_LN +: 2] = pfln_reg;
         rd_next[brc_pkg::F_PF_MU +: 2] = pfmu_reg;
      end else if (hit_is) begin
         rd_next[brc_pkg::IS_W-1:0] = ist_reg;
      end else if (hit_im) begin
         rd_next[brc_pkg::IS_W-1:0] = imsk_reg;
      end
   end

   // read data captured in setup, stable through access
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRDATA <= 32'h0000_0000;
      end else if (setup && !PWRITE) begin
         PRDATA <= rd_next;
      end
   end

   // plain read/write fields of chip control zero
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sdr_reg   <= 1'b0;              // RULE_01
         malf_reg  <= 1'b0;              // RULE_03
         mrbc_reg  <= brc_pkg::RST_MRBC; // RULE_04
         fcu_reg   <= 1'b0;
         rcl_reg   <= brc_pkg::RST_RCL;
         dtdis_reg <= 1'b0;
         dtsh_reg  <= 1'b0;
         crt_reg   <= brc_pkg::RST_CRT;  // RULE_12
      end else if (wr_acc && hit_c0) begin
         sdr_reg   <= PWDATA[brc_pkg::B_SDR];
         malf_reg  <= PWDATA[brc_pkg::B_MALF];
         mrbc_reg  <= PWDATA[brc_pkg::F_MRBC +: 3];
         fcu_reg   <= PWDATA[brc_pkg::B_FCU];
         rcl_reg   <= PWDATA[brc_pkg::F_RCL +: 2];
         dtdis_reg <= PWDATA[brc_pkg::B_DTDIS];
         dtsh_reg  <= PWDATA[brc_pkg::B_DTSHORT];
         crt_reg   <= PWDATA[brc_pkg::F_CRT +: 2];
      end
   end

   // sticky expiry: set wins over a same-cycle clear
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rcst_reg <= 1'b0;
      end else if (rc_expire) begin
         rcst_reg <= 1'b1; // RULE_07
      end else if (wr_acc && hit_c0 && PWDATA[brc_pkg::B_RCST]) begin
         rcst_reg <= 1'b0; // RULE_15
      end
   end

   // prefetch mode fields
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pfrd_reg <= brc_pkg::RST_PF_RD;
         pfln_reg <= brc_pkg::RST_PF_LN;
         pfmu_reg <= brc_pkg::RST_PF_MU;
      end else if (wr_acc && hit_pf) begin
         pfrd_reg <= PWDATA[brc_pkg::F_PF_RD +: 2];
         pfln_reg <= PWDATA[brc_pkg::F_PF_LN +: 2];
         pfmu_reg <= PWDATA[brc_pkg::F_PF_MU +: 2];
      end
   end

   // ---------------- transaction settings ----------------
   // catching fields at start keeps a write from changing a
   // transaction already under way
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         sdr_tx_reg   <= 1'b0;
         pcmd_reg     <= 4'h0;
         rcl_tx_reg   <= brc_pkg::RST_RCL;
         FULL_PF      <= 1'b0;
         MAX_RD_BYTES <= 13'h0200;
      end else if (TX_START) begin
         sdr_tx_reg   <= sdr_reg;  // RULE_15
         pcmd_reg     <= TX_CMD;
         rcl_tx_reg   <= rcl_reg;
         MAX_RD_BYTES <= mrbc_bytes(mrbc_reg); // RULE_04
         if (TX_CMD == brc_pkg::CMD_MR) begin
            FULL_PF <= (pfrd_reg == brc_pkg::PF_FULL); // RULE_13
         end else if (TX_CMD == brc_pkg::CMD_MRL) begin
            FULL_PF <= (pfln_reg != 2'h0);
         end else if (TX_CMD == brc_pkg::CMD_MRM) begin
            FULL_PF <= (pfmu_reg != 2'h0);
         end else begin
            FULL_PF <= 1'b0;
         end
      end
   end

   // ---------------- delayed read repeats ----------------
   assign rpt_same = (RPT_CMD == pcmd_reg);
   assign rpt_swap = sdr_tx_reg && is_mrd(RPT_CMD) &&
                     is_mrd(pcmd_reg); // RULE_02
   assign rpt_ok   = RPT_MATCH && (rpt_same || rpt_swap);

   // one answer pulse per repeat
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RPT_RETRY  <= 1'b0;
         RPT_ACCEPT <= 1'b0;
      end else begin
         RPT_ACCEPT <= RPT_VALID && rpt_ok;
         RPT_RETRY  <= RPT_VALID && !rpt_ok; // RULE_01
      end
   end

   // ---------------- retry counter ----------------
   assign rc_limit   = rc_lim(rcl_tx_reg);
   assign TX_ABANDON = rc_expire; // RULE_14

   brc_retry_cnt #(
      .CW     (32)
   ) u_rc (
      .clk    (CLK),
      .rstn   (RESETN),
      .retry  (RETRY_ISSUED || RPT_RETRY), // RULE_14
      .done   (TX_DONE),
      .limit  (rc_limit),
      .expire (rc_expire)
   );

   // ---------------- flow control credits ----------------
   assign MALF_CHECK_EN = malf_reg; // RULE_03

   // pairing halves the update traffic when bit 15 is clear
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         fc_half_reg <= 1'b0;
         FC_UPDATE   <= 1'b0;
      end else begin
         FC_UPDATE <= 1'b0;
         if (CREDIT_FREED) begin
            if (fcu_reg || fc_half_reg) begin
               FC_UPDATE   <= 1'b1; // RULE_06
               fc_half_reg <= 1'b0;
            end else begin
               fc_half_reg <= 1'b1;
            end
         end
      end
   end

   // ---------------- discard timer ----------------
   always_comb begin
      if (dtsh_reg) begin
         dt_len = TW'(brc_pkg::DT_SHORT); // RULE_10
      end else if (DT_SEL) begin
         dt_len = TW'(brc_pkg::DT_MID);
      end else begin
         dt_len = TW'(DTL_N);
      end
   end

   brc_timer #(
      .W       (TW)
   ) u_dt (
      .clk     (CLK),
      .rstn    (RESETN),
      .start   (DT_START),
      .stop    (DT_STOP),
      .enable  (!dtdis_reg), // RULE_09
      .length  (dt_len),
      .running (),
      .expire  (dt_exp)
   );
   assign DT_EXPIRE = dt_exp;

   // ---------------- config retry timer ----------------
   always_comb begin
      case (crt_reg)
         2'h0:    crs_len = TW'(brc_pkg::CRT0_CLKS); // RULE_11
         2'h1:    crs_len = TW'(CRT1_N);
         2'h2:    crs_len = TW'(CRT2_N);             // RULE_12
         default: crs_len = TW'(CRT3_N);
      endcase
   end

   brc_timer #(
      .W       (TW)
   ) u_crs (
      .clk     (CLK),
      .rstn    (RESETN),
      .start   (CRS_START),
      .stop    (CRS_STOP),
      .enable  (1'b1),
      .length  (crs_len),
      .running (),
      .expire  (crs_exp)
   );
   assign CRS_EXPIRE = crs_exp;

   // ---------------- interrupts ----------------
   always_comb begin
      ev               = '0;
      ev[brc_pkg::IS_RC]  = rc_expire;
      ev[brc_pkg::IS_DT]  = dt_exp;
      ev[brc_pkg::IS_CRT] = crs_exp;
   end

   // status: an event in the clearing cycle survives
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ist_reg <= '0;
      end else if (wr_acc && hit_is) begin
         ist_reg <= (ist_reg & ~PWDATA[brc_pkg::IS_W-1:0]) | ev;
      end else begin
         ist_reg <= ist_reg | ev;
      end
   end

   // mask register, all sources off after reset
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         imsk_reg <= '0;
      end else if (wr_acc && hit_im) begin
         imsk_reg <= PWDATA[brc_pkg::IS_W-1:0];
      end
   end

   // level output straight from the two registers
   assign IRQ = |(ist_reg & imsk_reg);
endmodule
`default_nettype wire

// ===== hdl/brc_pkg.sv
// Purpose: shared constants of the bridge read/retry control fields
// Assumes: 40 MHz core clock, APB byte addresses
// Notes:   times are kept in their own units, cycles derived from them
package brc_pkg;
   // register byte addresses
   localparam logic [11:0] OFF_CTRL0 = 12'h040; // chip control zero
   localparam logic [11:0] OFF_PFCTL = 12'h050; // read prefetch control
   localparam logic [11:0] OFF_ISTAT = 12'h054; // interrupt status
   localparam logic [11:0] OFF_IMASK = 12'h058; // interrupt mask

   // chip control zero field positions
   localparam int B_SDR     = 10; // special delayed read enable
   localparam int B_MALF    = 11; // optional malformed check enable
   localparam int F_MRBC    = 12; // max read byte count, 3 bits
   localparam int B_FCU     = 15; // flow control update per credit
   localparam int B_RCST    = 16; // retry counter expired, sticky
   localparam int F_RCL     = 17; // retry counter limit, 2 bits
   localparam int B_DTDIS   = 19; // discard timer disable
   localparam int B_DTSHORT = 20; // discard timer short duration
   localparam int F_CRT     = 21; // config retry timer, 2 bits

   // read prefetch control field positions
   localparam int F_PF_RD = 0; // memory read mode
   localparam int F_PF_LN = 2; // read line mode
   localparam int F_PF_MU = 4; // read multiple mode

   // reset values
   localparam logic [2:0] RST_MRBC  = 3'h0;
   localparam logic [1:0] RST_RCL   = 2'h0;
   localparam logic [1:0] RST_CRT   = 2'h1;
   localparam logic [1:0] RST_PF_RD = 2'h0;
   localparam logic [1:0] RST_PF_LN = 2'h0;
   localparam logic [1:0] RST_PF_MU = 2'h2;
   localparam logic [1:0] PF_FULL   = 2'h2; // full prefetch code

   // interrupt status bits
   localparam int IS_RC  = 0; // retry counter expired
   localparam int IS_DT  = 1; // discard timer expired
   localparam int IS_CRT = 2; // config retry timer expired
   localparam int IS_W   = 3;

   // memory read command codes
   localparam logic [3:0] CMD_MR  = 4'h6;
   localparam logic [3:0] CMD_MRM = 4'hC;
   localparam logic [3:0] CMD_MRL = 4'hE;

   // retry limits
   localparam int RC_LIM1 = 256;
   localparam int RC_LIM2 = 65536;
   localparam int RC_LIM3 = 32'h8000_0000;

   // timing
   localparam real CLK_NS     = 25.0;
   localparam real CRT0_US    = 25.0;
   localparam real CRT1_MS    = 0.5;
   localparam real CRT2_MS    = 5.0;
   localparam real CRT3_MS    = 25.0;
   localparam int  CRT0_CLKS  = int'(CRT0_US * 1.0E3 / CLK_NS);
   localparam int  CRT1_CLKS  = int'(CRT1_MS * 1.0E6 / CLK_NS);
   localparam int  CRT2_CLKS  = int'(CRT2_MS * 1.0E6 / CLK_NS);
   localparam int  CRT3_CLKS  = int'(CRT3_MS * 1.0E6 / CLK_NS);
   localparam int  DT_SHORT   = 64;    // short discard, PCI clocks
   localparam int  DT_MID     = 1024;  // bridge-control short choice
   localparam int  DT_LONG    = 32768; // bridge-control long choice
   localparam int  TMR_W      = 20;    // timer counter width
endpackage

// ===== hdl/brc_retry_cnt.sv
// Purpose: counts retries of the pending transaction
// Assumes: retry and done are one-cycle pulses
// Notes:   a zero limit means the count never expires
`timescale 1ns/1ps
`default_nettype none
module brc_retry_cnt #(
   parameter int CW = 32
) (
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire logic          retry,  // retry issued this cycle
   input  wire logic          done,   // pending transaction completed
   input  wire logic [CW-1:0] limit,  // retries allowed, zero is none
   output logic               expire  // pulse when limit reached
);
   logic [CW-1:0] count_reg; // consecutive retries so far
   logic [CW-1:0] count_inc;

   assign count_inc = count_reg + 1'b1;

   // count, clear on completion or on expiry
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
         expire    <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (done) begin
            count_reg <= '0;
         end else if (retry) begin
            if (limit != '0 && count_inc == limit) begin
               count_reg <= '0;
               expire    <= 1'b1;
            end else if (count_inc != '0) begin
               // saturate rather than wrap when unlimited
               count_reg <= count_inc;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== hdl/brc_timer.sv
// Purpose: one-shot expiry timer
// Assumes: length is at least one
// Notes:   expire pulses length cycles after start
`timescale 1ns/1ps
`default_nettype none
module brc_timer #(
   parameter int W = 20
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         start,   // load and run
   input  wire logic         stop,    // abandon the count
   input  wire logic         enable,  // low stops the count, blocks start
   input  wire logic [W-1:0] length,  // cycles to expiry
   output logic              running, // count in progress
   output logic              expire   // one-cycle pulse
);
   logic [W-1:0] cnt_reg; // cycles left

   // down counter, start wins over stop
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
         running <= 1'b0;
         expire  <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (!enable) begin
            running <= 1'b0;
         end else if (start) begin
            cnt_reg <= length;
            running <= 1'b1;
         end else if (stop) begin
            running <= 1'b0;
         end else if (running) begin
            if (cnt_reg <= W'(1)) begin
               running <= 1'b0;
               expire  <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== bench/brc_checker.sv
// Purpose: port-level checks on the control field block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every brc_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module brc_checker (
   input wire logic        CLK,
   input wire logic        RESETN,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        RPT_VALID,
   input wire logic        RPT_MATCH,
   input wire logic        RPT_RETRY,
   input wire logic        RPT_ACCEPT,
   input wire logic        CREDIT_FREED,
   input wire logic        FC_UPDATE,
   input wire logic        TX_ABANDON,
   input wire logic [12:0] MAX_RD_BYTES
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // a repeat gets exactly one of the two answers next cycle
   sequence s_repeat; RPT_VALID; endsequence
   sequence s_answer; RPT_RETRY ^ RPT_ACCEPT; endsequence
   a_repeat_answer: assert property (s_repeat |=> s_answer)
      else $error("repeat not answered");
   a_mismatch_retry: assert property (s_repeat and !RPT_MATCH |=> RPT_RETRY)
      else $error("mismatched repeat accepted");
   a_no_stray: assert property (!RPT_VALID |=> !RPT_RETRY && !RPT_ACCEPT)
      else $error("answer without repeat");
   a_byte_legal: assert property (MAX_RD_BYTES inside {128, 256, 512, 1024, 2048, 4096})
      else $error("illegal byte count");
   a_fc_cause: assert property (FC_UPDATE |-> $past(CREDIT_FREED))
      else $error("update without freed credit");
   a_abandon_pulse: assert property (TX_ABANDON |=> !TX_ABANDON)
      else $error("abandon longer than one cycle");
   a_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("error outside access phase");
   a_ready_high: assert property (PREADY)
      else $error("ready low");
endmodule
bind brc_ctrl brc_checker brc_checker_inst (.CLK, .RESETN, .PSEL, .PENABLE,
   .PREADY, .PSLVERR, .RPT_VALID, .RPT_MATCH, .RPT_RETRY, .RPT_ACCEPT,
   .CREDIT_FREED, .FC_UPDATE, .TX_ABANDON, .MAX_RD_BYTES);
`default_nettype wire

// ===== bench/brc_ctrl_tb.sv
// Purpose: self-checking bench for the control field block
// Assumes: zero-wait APB, small timer and limit parameters
// Notes:   expected values come from the field tables
`timescale 1ns/1ps
`default_nettype none
module brc_ctrl_tb;
   logic        CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [11:0] PADDR = '0;
   logic [31:0] PWDATA = '0, PRDATA, rd;
   logic        PREADY, PSLVERR, err, TX_START = 0, TX_DONE = 0;
   logic [3:0]  TX_CMD = 4'h6, RPT_CMD = 4'h6;
   logic        RETRY_ISSUED = 0, RPT_VALID = 0, RPT_MATCH = 0, DT_STOP = 0;
   logic        RPT_RETRY, RPT_ACCEPT, TX_ABANDON, FULL_PF, MALF_CHECK_EN;
   logic        CREDIT_FREED = 0, FC_UPDATE, DT_SEL = 0, DT_START = 0;
   logic        DT_EXPIRE, CRS_START = 0, CRS_EXPIRE, IRQ, CRS_STOP = 0;
   logic [12:0] MAX_RD_BYTES;
   int          n_mismatch = 0, checks = 0, n_fc = 0, n_ab = 0;
   int          bytes [8] = '{512, 128, 256, 512, 1024, 2048, 4096, 512};
   // short counts keep the run brief
   brc_ctrl #(.CRT1_N(50), .CRT2_N(60), .CRT3_N(70), .DTL_N(40),
      .RC_MID(8), .RC_MAX(16)) brc_ctrl_inst (.CLK, .RESETN, .PSEL,
      .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .PRDATA,
      .TX_START, .TX_CMD, .TX_DONE, .RETRY_ISSUED, .RPT_VALID, .RPT_CMD,
      .RPT_MATCH, .RPT_RETRY, .RPT_ACCEPT, .TX_ABANDON, .FULL_PF,
      .MAX_RD_BYTES, .MALF_CHECK_EN, .CREDIT_FREED, .FC_UPDATE, .DT_SEL,
      .DT_START, .DT_STOP, .DT_EXPIRE, .CRS_START, .CRS_STOP,
      .CRS_EXPIRE, .IRQ);
   always #12.5 CLK = ~CLK;
   // count one-cycle output pulses
   always @(posedge CLK) begin
      if (FC_UPDATE === 1'b1) n_fc++;
      if (TX_ABANDON === 1'b1) n_ab++;
   end
   task give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // apb transfer; request held until ready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
         k++;
      end while (PREADY !== 1'b1 && k < 50);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task drv(input int s, input logic v);
      case (s)
         0: TX_START <= v;
         1: TX_DONE <= v;
         2: CREDIT_FREED <= v;
         3: DT_START <= v;
         4: CRS_START <= v;
         5: DT_STOP <= v;
         default: CRS_STOP <= v;
      endcase
   endtask
   task pulse(input int s);
      @(posedge CLK) drv(s, 1'b1);
      @(posedge CLK) drv(s, 1'b0);
   endtask
   // pulse a timer start or stop input and count cycles to its expiry pulse
   task tmr(input int s, input int exp);
      int k;
      k = 0;
      pulse(s);
      do begin
         @(posedge CLK);
         k++;
         #1;
      end while (((s % 2) ? DT_EXPIRE : CRS_EXPIRE) !== 1'b1 && k < 1200);
      chk(k, exp);
   endtask
   task rpt(input logic [3:0] c, input logic m, input logic acc);
      @(posedge CLK);
      RPT_CMD <= c;
      RPT_MATCH <= m;
      RPT_VALID <= 1'b1;
      @(posedge CLK);
      RPT_VALID <= 1'b0;
      #1 chk({RPT_RETRY, RPT_ACCEPT}, {!acc, acc});
   endtask
   task retry(input int n);
      @(posedge CLK) RETRY_ISSUED <= 1'b1;
      repeat (n) @(posedge CLK);
      RETRY_ISSUED <= 1'b0;
      repeat (3) @(posedge CLK);
   endtask
   task t_regs;
      apb(0, 12'h040, 0);
      chk(rd, 32'h0020_0000);
      chk(MAX_RD_BYTES, 512);
      chk(MALF_CHECK_EN, 0);
      apb(0, 12'h050, 0);
      chk(rd, 32'h20);
      apb(1, 12'h040, 32'hFFFF_FFFF);
      apb(0, 12'h040, 0);
      chk(rd, 32'h007E_FC00);
      chk(MALF_CHECK_EN, 1);
      apb(1, 12'h05C, 32'hFFFF_FFFF);
      chk(err, 1);
      apb(0, 12'h05C, 0);
      chk(err, 1);
      chk(rd, 0);
   endtask
   task t_bytes;
      for (int i = 0; i < 8; i++) begin
         apb(1, 12'h040, 32'(i) << 12);
         pulse(0);
         @(posedge CLK) #1 chk(MAX_RD_BYTES, bytes[i]);
      end
      chk(FULL_PF, 0);
      apb(1, 12'h050, 32'h2);
      pulse(0);
      @(posedge CLK) #1 chk(FULL_PF, 1);
      apb(1, 12'h050, 32'h8);
      TX_CMD <= 4'hE;
      pulse(0);
      @(posedge CLK) #1 chk(FULL_PF, 1);
   endtask
   task t_repeat;
      apb(1, 12'h040, 0);
      pulse(0);
      rpt(4'h6, 1, 0);
      rpt(4'hE, 1, 1);
      apb(1, 12'h040, 32'h400);
      pulse(0);
      rpt(4'h6, 1, 1);
      rpt(4'hC, 1, 1);
      rpt(4'hC, 0, 0);
   endtask
   task t_flow;
      for (int b = 0; b < 2; b++) begin
         apb(1, 12'h040, 32'(b) << 15);
         n_fc = 0;
         repeat (4) pulse(2);
         repeat (3) @(posedge CLK);
         chk(n_fc, b ? 4 : 2);
      end
   endtask
   task t_retry;
      apb(1, 12'h040, 32'h4_0000);
      pulse(1);
      pulse(0);
      n_ab = 0;
      retry(7);
      pulse(1);
      retry(7);
      chk(n_ab, 0);
      retry(1);
      chk(n_ab, 1);
      #1 chk(IRQ, 0);
      apb(0, 12'h040, 0);
      chk(rd[16], 1);
      apb(1, 12'h058, 1);
      #1 chk(IRQ, 1);
      apb(1, 12'h040, 32'h2_0000);
      apb(0, 12'h040, 0);
      chk(rd[16], 1);
      apb(1, 12'h040, 32'h3_0000);
      apb(0, 12'h040, 0);
      chk(rd[16], 0);
      apb(1, 12'h054, 1);
      #1 chk(IRQ, 0);
      pulse(1);
      pulse(0);
      retry(255);
      chk(n_ab, 1);
      retry(1);
      chk(n_ab, 2);
   endtask
   task t_timers;
      apb(1, 12'h040, 32'h10_0000);
      tmr(3, 64);
      apb(1, 12'h040, 32'h18_0000);
      tmr(3, 1200);
      apb(1, 12'h040, 0);
      tmr(3, 40);
      @(posedge CLK) DT_SEL <= 1'b1;
      tmr(3, 1024);
      pulse(3);
      tmr(5, 1200);
      tmr(4, 1000);
      pulse(4);
      tmr(6, 1200);
      for (int c = 1; c < 4; c++) begin
         apb(1, 12'h040, 32'(c) << 21);
         tmr(4, 40 + 10 * c);
      end
   endtask
   initial begin
      repeat (5) @(posedge CLK);
      RESETN <= 1'b1;
      t_regs;
      t_bytes;
      t_repeat;
      t_flow;
      t_retry;
      t_timers;
      give_verdict;
   end
   // cut a hang short
   initial begin
      #500000;
      n_mismatch++;
      give_verdict;
   end
endmodule
`default_nettype wire
